// File: rtl/pbt_top.sv
// Contract
// (R1) failed delivery drops data, gated serr
// (R2) retry delivery up to attempt limit
// (R3) disconnected mwi resumes as memory write
// (R4) retry while busy or buffer holds data
// (R5) retry when wait timer expires ungranted
// (R6) retry lock held by another initiator
// (R7) single dword for non-posted, non-prefetched
// (R8) disconnect when buffer fills before trdy
// (R9) disconnect when refill after latency expiry; posting never looks at mlt_exp, only a full buffer before trdy disconnects
// (R10) disconnect posted write at write boundary
// (R11) disconnect prefetch read on latency expiry
// (R12) disconnect prefetch read at read boundary
// (R13) disconnect when burst limit reached
// (R14) target abort only for two causes
// (R15) forward and ignore are complementary
// (R16) non-prefetchable range, inclusive, 1 MB
// (R17) prefetchable range, inclusive, 1 MB
// (R18) downstream only inside ranges, overlap non-pref
// (R19) upstream when outside both ranges
// (R20) limit below base disables range
// (R21) reset ranges cover first megabyte
// (R22) frame buffer window forwards downstream, prefetch
// (R23) dual address always upstream only
// (R24) decide forwarding at address phase
`timescale 1ns/1ps
`include "pbt_defs.svh"
module pbt_top import pbt_pkg::*; #(
	parameter int unsigned ATTEMPT_MAX = `PBT_ATTEMPT_MAX
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_we,
	input  wire logic         reg_re,
	output logic [31:0]       reg_rdata,
	input  wire pbt_addr_ph_t ap,
	input  wire pbt_busy_t    busy,
	input  wire pbt_tgt_t     tgt,
	input  wire logic         init_dv,
	input  wire logic         init_last,
	input  wire logic         burst_lim,
	input  wire logic [7:0]   cache_line_dw,
	output pbt_term_t         term,
	output logic              dlv_mw,
	output logic              drop,
	output logic              serr_o,
	output logic              serr_oe_n
);

	pbt_top_st_t st_reg;
	pbt_top_st_t st_next;
	logic        dec_fwd;
	logic        dec_pref;
	logic        att_inc;
	logic        att_clr;
	logic [23:0] att_count;
	logic        att_last;
	logic [3:0]  wcnt_n;
	logic        posted_ap;
	logic        busy_ret;
	logic        lock_ret;
	logic        drain;

	function automatic logic bnd_hit(input logic [7:0] off, input logic [7:0] cls,
		input logic line);
		logic [7:0] nxt;
		nxt = off + 8'h01;
		if (line) begin
			return (nxt & (cls - 8'h01)) == 8'h00;
		end
		return nxt == 8'h00;
	endfunction

	pbt_mem_decode u_dec (
		.ap        (ap),
		.mem_base  (st_reg.mem_base),
		.mem_lim   (st_reg.mem_lim),
		.pmem_base (st_reg.pmem_base),
		.pmem_lim  (st_reg.pmem_lim),
		.vga_en    (st_reg.ctl[`PBT_CTL_VGA_EN]),
		.fwd       (dec_fwd),
		.pref      (dec_pref)
	);

	pbt_att_cnt #(
		.ATTEMPT_MAX (ATTEMPT_MAX)
	) u_att (
		.core_clk (core_clk),
		.rstn     (rstn),
		.clr      (att_clr),
		.inc      (att_inc),
		.count    (att_count),
		.last     (att_last)
	);

	// a stray target ready on an empty buffer must not wrap the count
	assign drain     = tgt.trdy && (st_reg.state inside {PBT_POST, PBT_DELIV}) &&
		((st_reg.wcnt != 4'h0) || (init_dv && (st_reg.state == PBT_POST)));
	// buffer level after this cycle's fill from initiator and drain to target
	assign wcnt_n    = st_reg.wcnt + {3'h0, init_dv && (st_reg.state == PBT_POST)}
		- {3'h0, drain};
	assign posted_ap = (ap.cmd == PBT_CMD_MEM_WR) || (ap.cmd == PBT_CMD_MWI);
	// posted writes may run against an opposite-direction posting stream
	assign busy_ret  = busy.xfer_busy || busy.wbuf_this ||
		(!posted_ap && (busy.opp_busy || busy.wbuf_opp)); // (R4)
	assign lock_ret  = ap.lock && busy.lock_other; // (R6)

	always_comb begin
		st_next           = st_reg;
		st_next.term      = '0;
		st_next.drop      = 1'b0;
		st_next.serr_o    = 1'b0;
		st_next.serr_oe_n = 1'b1;
		st_next.rdata     = 32'h00000000;
		att_inc           = 1'b0;
		att_clr           = 1'b0;

		if (reg_we) begin
			case (reg_addr)
				`PBT_OFF_MEM: begin
					st_next.mem_base = reg_wdata[`PBT_BASE_MSB:`PBT_BASE_LSB];
					st_next.mem_lim  = reg_wdata[`PBT_LIM_MSB:`PBT_LIM_LSB];
				end
				`PBT_OFF_PMEM: begin
					st_next.pmem_base = reg_wdata[`PBT_BASE_MSB:`PBT_BASE_LSB];
					st_next.pmem_lim  = reg_wdata[`PBT_LIM_MSB:`PBT_LIM_LSB];
				end
				`PBT_OFF_CTRL: begin
					st_next.ctl = reg_wdata[3:0];
				end
				`PBT_OFF_STAT: begin
					if (reg_wdata[`PBT_ST_DLV_FAIL]) begin
						st_next.dlv_fail = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (reg_re) begin
			case (reg_addr)
				`PBT_OFF_MEM: begin
					st_next.rdata[`PBT_BASE_MSB:`PBT_BASE_LSB] = st_reg.mem_base;
					st_next.rdata[`PBT_LIM_MSB:`PBT_LIM_LSB]   = st_reg.mem_lim;
				end
				`PBT_OFF_PMEM: begin
					st_next.rdata[`PBT_BASE_MSB:`PBT_BASE_LSB] = st_reg.pmem_base;
					st_next.rdata[`PBT_LIM_MSB:`PBT_LIM_LSB]   = st_reg.pmem_lim;
				end
				`PBT_OFF_CTRL: begin
					st_next.rdata[3:0] = st_reg.ctl;
				end
				`PBT_OFF_STAT: begin
					st_next.rdata[`PBT_ST_DLV_FAIL] = st_reg.dlv_fail;
					st_next.rdata[`PBT_ST_BUSY]     = (st_reg.state != PBT_IDLE);
					st_next.rdata[`PBT_ST_MW_DOWN]  = st_reg.mw_down;
					st_next.rdata[`PBT_ST_CNT_MSB:`PBT_ST_CNT_LSB] = st_reg.wcnt;
				end
				`PBT_OFF_ATT: begin
					st_next.rdata[23:0] = att_count;
				end
				default: begin
				end
			endcase
		end

		case (st_reg.state)
			PBT_IDLE: begin
				// decision taken on the address phase itself, before claiming
				if (ap.valid && dec_fwd) begin // (R24)
					st_next.term.claim = 1'b1;
					st_next.term.pref  = dec_pref;
					st_next.pref       = dec_pref;
					st_next.mwi        = (ap.cmd == PBT_CMD_MWI);
					st_next.line_bnd   = (ap.cmd == PBT_CMD_MEM_RD);
					st_next.dw_off     = ap.addr[9:2];
					st_next.wcnt       = 4'h0;
					st_next.att_trdy   = 1'b0;
					st_next.mw_down    = 1'b0;
					if (busy_ret || lock_ret) begin // (R4) (R6)
						st_next.term.retry = 1'b1;
					end else if (posted_ap) begin
						st_next.state = PBT_POST;
					end else begin
						st_next.state = PBT_WAIT;
					end
				end
			end
			PBT_WAIT: begin
				if (tgt.twt_exp && !tgt.gnt) begin // (R5)
					st_next.term.retry = 1'b1;
					st_next.state      = PBT_IDLE;
				end else if (tgt.tabort ||
					(tgt.mabort && st_reg.ctl[`PBT_CTL_MA_MODE])) begin // (R14)
					st_next.term.tabort = 1'b1;
					st_next.state       = PBT_IDLE;
				end else if (tgt.mabort) begin
					// no target: the single dword completes with all ones
					st_next.term.disc = 1'b1;
					st_next.state     = PBT_IDLE;
				end else if (tgt.retry) begin
					st_next.term.retry = 1'b1;
					st_next.state      = PBT_IDLE;
				end else if (tgt.trdy) begin
					if (st_reg.pref) begin
						st_next.state = PBT_PREF;
					end else begin
						st_next.term.disc = 1'b1; // (R7)
						st_next.state     = PBT_IDLE;
					end
				end
			end
			PBT_PREF: begin
				if (tgt.tabort) begin
					st_next.term.tabort = 1'b1; // (R14)
					st_next.state       = PBT_IDLE;
				end else if (init_dv) begin
					st_next.dw_off = st_reg.dw_off + 8'h01;
					if (init_last) begin
						st_next.state = PBT_IDLE;
					end else if (tgt.mlt_exp || tgt.disc || burst_lim || // (R11) (R13)
						bnd_hit(st_reg.dw_off, cache_line_dw, st_reg.line_bnd)) begin // (R12)
						st_next.term.disc = 1'b1;
						st_next.state     = PBT_IDLE;
					end
				end
			end
			PBT_POST, PBT_DELIV: begin
				st_next.wcnt = wcnt_n;
				if (drain) begin
					st_next.att_trdy = 1'b1;
				end
				if (st_reg.mwi && tgt.disc) begin
					st_next.mw_down = 1'b1; // (R3)
				end
				if (tgt.tabort) begin
					// posted data behind a target abort is never retried
					st_next.drop  = 1'b1;
					st_next.wcnt  = 4'h0;
					st_next.state = PBT_IDLE;
					att_clr       = 1'b1;
				end else if (tgt.att_end && (wcnt_n != 4'h0)) begin
					st_next.att_trdy = 1'b0;
					if (att_last) begin // (R2)
						st_next.drop     = 1'b1; // (R1)
						st_next.dlv_fail = 1'b1;
						st_next.wcnt     = 4'h0;
						st_next.state    = PBT_IDLE;
						att_clr          = 1'b1;
						if (st_reg.ctl[`PBT_CTL_SERR_EN] && !st_reg.ctl[`PBT_CTL_DLV_DIS]) begin
							st_next.serr_oe_n = 1'b0; // (R1)
						end
					end else begin
						att_inc = 1'b1; // (R2)
					end
				end else if ((st_reg.state == PBT_DELIV) && (wcnt_n == 4'h0)) begin
					st_next.state = PBT_IDLE;
					att_clr       = 1'b1;
				end
				if ((st_reg.state == PBT_POST) && init_dv && !tgt.tabort) begin
					st_next.dw_off = st_reg.dw_off + 8'h01;
					if (init_last) begin
						st_next.state = PBT_DELIV;
					end else if (((wcnt_n == `PBT_WBUF_DWORDS) && !st_reg.att_trdy && // (R8) (R9)
						!tgt.trdy) || burst_lim || // (R13)
						bnd_hit(st_reg.dw_off, cache_line_dw, st_reg.mwi)) begin // (R10)
						st_next.term.disc = 1'b1;
						st_next.state     = PBT_DELIV;
					end
				end
			end
			default: begin
				st_next.state = PBT_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg           <= '0;
			st_reg.state     <= PBT_IDLE;
			st_reg.mem_base  <= `PBT_RST_BASE; // (R21)
			st_reg.mem_lim   <= `PBT_RST_LIMIT; // (R21)
			st_reg.pmem_base <= `PBT_RST_BASE; // (R21)
			st_reg.pmem_lim  <= `PBT_RST_LIMIT; // (R21)
			st_reg.ctl       <= `PBT_RST_CTRL;
			st_reg.serr_oe_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign term      = st_reg.term;
	assign dlv_mw    = st_reg.mw_down;
	assign drop      = st_reg.drop;
	assign serr_o    = st_reg.serr_o;
	assign serr_oe_n = st_reg.serr_oe_n;

	chk_serr_only_drop: assert property (@(posedge core_clk) disable iff (!rstn) // (R1)
		!serr_oe_n |-> (drop && st_reg.ctl[`PBT_CTL_SERR_EN] && !st_reg.ctl[`PBT_CTL_DLV_DIS]))
		else $error("serr driven without an enabled delivery failure");

	chk_drop_after_limit: assert property (@(posedge core_clk) disable iff (!rstn) // (R2)
		drop |-> ($past(att_last) && $past(tgt.att_end)) || $past(tgt.tabort))
		else $error("posted data dropped before the attempt limit");

	chk_busy_retry: assert property (@(posedge core_clk) disable iff (!rstn) // (R4)
		(st_reg.state == PBT_IDLE && ap.valid && dec_fwd && busy.xfer_busy)
		|=> (term.retry && st_reg.state == PBT_IDLE))
		else $error("busy bridge did not retry");

	chk_wait_retry: assert property (@(posedge core_clk) disable iff (!rstn) // (R5)
		(st_reg.state == PBT_WAIT && tgt.twt_exp && !tgt.gnt) |=> term.retry ##1 !term.retry)
		else $error("expired wait timer without retry");

	chk_lock_retry: assert property (@(posedge core_clk) disable iff (!rstn) // (R6)
		(st_reg.state == PBT_IDLE && ap.valid && dec_fwd && ap.lock && busy.lock_other)
		|=> term.retry)
		else $error("foreign lock not retried");

	chk_single_dword: assert property (@(posedge core_clk) disable iff (!rstn) // (R7)
		(st_reg.state == PBT_WAIT && !st_reg.pref && tgt.trdy && !tgt.retry && !tgt.tabort
		&& !tgt.mabort && !(tgt.twt_exp && !tgt.gnt)) |=> (term.disc && st_reg.state == PBT_IDLE))
		else $error("non-prefetched transfer not limited to one dword");

	chk_full_disc: assert property (@(posedge core_clk) disable iff (!rstn) // (R8)
		(st_reg.state == PBT_POST && init_dv && !init_last && !tgt.tabort && !tgt.trdy
		&& !st_reg.att_trdy && wcnt_n == `PBT_WBUF_DWORDS) |=> term.disc)
		else $error("full write buffer did not disconnect");

	chk_abort_cause: assert property (@(posedge core_clk) disable iff (!rstn) // (R14)
		term.tabort |-> ($past(tgt.tabort) ||
		($past(tgt.mabort) && $past(st_reg.ctl[`PBT_CTL_MA_MODE])))
		&& $past(st_reg.state) != PBT_POST && $past(st_reg.state) != PBT_DELIV)
		else $error("target abort without a permitted cause");

	chk_dac_direction: assert property (@(posedge core_clk) disable iff (!rstn) // (R23)
		(st_reg.state == PBT_IDLE && ap.valid && ap.dac && ap.cmd == PBT_CMD_MEM_RD)
		|=> (term.claim == $past(ap.from_sec)))
		else $error("dual address cycle forwarded the wrong way");

endmodule // pbt_top

// File: rtl/pbt_defs.svh
`ifndef PBT_DEFS_SVH
`define PBT_DEFS_SVH

// register byte offsets
`define PBT_OFF_MEM      8'h00
`define PBT_OFF_PMEM     8'h04
`define PBT_OFF_CTRL     8'h08
`define PBT_OFF_STAT     8'h0c
`define PBT_OFF_ATT      8'h10

// base/limit layout: address bits 31:20 of the range, 1 MB granules
`define PBT_BASE_LSB     4
`define PBT_BASE_MSB     15
`define PBT_LIM_LSB      20
`define PBT_LIM_MSB      31

// control bits
`define PBT_CTL_SERR_EN  0
`define PBT_CTL_DLV_DIS  1
`define PBT_CTL_MA_MODE  2
`define PBT_CTL_VGA_EN   3

// status bits
`define PBT_ST_DLV_FAIL  0
`define PBT_ST_BUSY      1
`define PBT_ST_MW_DOWN   2
`define PBT_ST_CNT_LSB   4
`define PBT_ST_CNT_MSB   7

// reset values
`define PBT_RST_BASE     12'h000
`define PBT_RST_LIMIT    12'h000
`define PBT_RST_CTRL     4'h0

// counts
`define PBT_ATTEMPT_MAX  16777216
`define PBT_WBUF_DWORDS  4'h8

// frame-buffer window
`define PBT_VGA_LO       32'h000a0000
`define PBT_VGA_HI       32'h000bffff

`endif

// File: rtl/pbt_pkg.sv
package pbt_pkg;

	typedef enum logic [2:0] {
		PBT_CMD_MEM_RD,
		PBT_CMD_MEM_RD_LINE,
		PBT_CMD_MEM_RD_MULT,
		PBT_CMD_MEM_WR,
		PBT_CMD_MWI,
		PBT_CMD_IO_RD,
		PBT_CMD_IO_WR,
		PBT_CMD_OTHER
	} pbt_cmd_t;

	typedef enum logic [2:0] {
		PBT_IDLE,
		PBT_WAIT,
		PBT_PREF,
		PBT_POST,
		PBT_DELIV
	} pbt_state_t;

	typedef struct packed {
		logic        valid;
		logic        from_sec;
		logic        dac;
		logic        lock;
		pbt_cmd_t    cmd;
		logic [31:0] addr;
	} pbt_addr_ph_t;

	typedef struct packed {
		logic xfer_busy;
		logic opp_busy;
		logic wbuf_this;
		logic wbuf_opp;
		logic lock_other;
	} pbt_busy_t;

	typedef struct packed {
		logic gnt;
		logic twt_exp;
		logic mlt_exp;
		logic trdy;
		logic retry;
		logic disc;
		logic tabort;
		logic mabort;
		logic att_end;
	} pbt_tgt_t;

	typedef struct packed {
		logic claim;
		logic retry;
		logic disc;
		logic tabort;
		logic pref;
	} pbt_term_t;

	typedef struct packed {
		pbt_state_t  state;
		logic [11:0] mem_base;
		logic [11:0] mem_lim;
		logic [11:0] pmem_base;
		logic [11:0] pmem_lim;
		logic [3:0]  ctl;
		logic        dlv_fail;
		logic        pref;
		logic        mwi;
		logic        line_bnd;
		logic [7:0]  dw_off;
		logic [3:0]  wcnt;
		logic        att_trdy;
		logic        mw_down;
		pbt_term_t   term;
		logic        drop;
		logic        serr_o;
		logic        serr_oe_n;
		logic [31:0] rdata;
	} pbt_top_st_t;

	typedef struct packed {
		logic [23:0] count;
	} pbt_att_st_t;

endpackage

// File: rtl/pbt_mem_decode.sv
`timescale 1ns/1ps
`include "pbt_defs.svh"
module pbt_mem_decode import pbt_pkg::*; (
	input  wire pbt_addr_ph_t ap,
	input  wire logic [11:0]  mem_base,
	input  wire logic [11:0]  mem_lim,
	input  wire logic [11:0]  pmem_base,
	input  wire logic [11:0]  pmem_lim,
	input  wire logic         vga_en,
	output logic              fwd,
	output logic              pref
);

	// a limit below its base gives an empty range by itself
	function automatic logic in_rng(input logic [11:0] mb, input logic [11:0] lo,
		input logic [11:0] hi);
		return (lo <= mb) && (mb <= hi);
	endfunction

	logic is_mem;
	logic hit_np;
	logic hit_p;
	logic hit_vga;

	assign is_mem  = (ap.cmd == PBT_CMD_MEM_RD) || (ap.cmd == PBT_CMD_MEM_RD_LINE) ||
		(ap.cmd == PBT_CMD_MEM_RD_MULT) || (ap.cmd == PBT_CMD_MEM_WR) ||
		(ap.cmd == PBT_CMD_MWI);
	assign hit_np  = in_rng(ap.addr[31:20], mem_base, mem_lim); // (R16) (R20) (R21)
	assign hit_p   = in_rng(ap.addr[31:20], pmem_base, pmem_lim); // (R17) (R20) (R21)
	assign hit_vga = vga_en && (ap.addr >= `PBT_VGA_LO) && (ap.addr <= `PBT_VGA_HI); // (R22)

	always_comb begin
		fwd  = 1'b0;
		pref = 1'b0;
		if (is_mem) begin
			if (ap.dac) begin
				fwd = ap.from_sec; // (R23)
			end else if (ap.from_sec) begin
				fwd = !(hit_np || hit_p || hit_vga); // (R15) (R19) (R22)
			end else begin
				fwd  = hit_np || hit_p || hit_vga; // (R15) (R18)
				pref = !hit_np && (hit_p || hit_vga); // (R18) (R22)
			end
		end
	end

endmodule // pbt_mem_decode

// File: rtl/pbt_att_cnt.sv
`timescale 1ns/1ps
`include "pbt_defs.svh"
module pbt_att_cnt import pbt_pkg::*; #(
	parameter int unsigned ATTEMPT_MAX = `PBT_ATTEMPT_MAX
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        clr,
	input  wire logic        inc,
	output logic [23:0]      count,
	output logic             last
);

	pbt_att_st_t st_reg;
	pbt_att_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (clr) begin
			st_next.count = 24'h000000;
		end else if (inc) begin
			st_next.count = st_reg.count + 24'h000001; // (R2)
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign count = st_reg.count;
	assign last  = (st_reg.count == 24'(ATTEMPT_MAX - 1)); // (R2)

	chk_att_clear_zero: assert property (@(posedge core_clk) disable iff (!rstn) // (R2)
		clr |=> (count == 24'h000000))
		else $error("attempt count not cleared");

endmodule // pbt_att_cnt

// File: testbench/pbt_far_model.sv
`timescale 1ns/1ps
module pbt_far_model import pbt_pkg::*; (
	input	wire logic		core_clk,
	input	wire logic		rstn,
	input	wire logic [2:0]	mode,
	input	wire pbt_term_t	term,
	input	wire logic		drop,
	output	pbt_tgt_t		tgt
);
	// mode 0 never granted, 1 trdy, 2 target abort, 3 no response,
	// 4 retry every attempt, 5 disconnect every attempt, 6 accept every
	// other cycle, 7 trdy with latency timer already expired
	logic	dlv_reg;
	logic	tog_reg;
	wire	hit = term.claim && !term.retry;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tgt <= '0;
			dlv_reg <= 1'b0;
			tog_reg <= 1'b0;
		end else begin
			tog_reg <= !tog_reg;
			tgt <= '0;
			tgt.gnt <= mode != 3'h0;
			tgt.mlt_exp <= mode == 3'h7;
			// timer stays expired until the bridge has answered with retry
			tgt.twt_exp <= mode == 3'h0 && (tgt.twt_exp || hit) && !term.retry;
			tgt.trdy <= (hit && (mode == 3'h1 || mode == 3'h7)) || (mode == 3'h6 && tog_reg);
			tgt.tabort <= hit && mode == 3'h2;
			tgt.mabort <= hit && mode == 3'h3;
			if (term.disc && mode[2:1] == 2'b10)
				dlv_reg <= 1'b1;
			if (drop || mode[2:1] != 2'b10)
				dlv_reg <= 1'b0;
			// no further attempt once the bridge has dropped its data
			if (dlv_reg && tog_reg && !drop) begin
				tgt.att_end <= 1'b1;
				tgt.retry <= !mode[0];
				tgt.disc <= mode[0];
			end
		end
	end
endmodule // pbt_far_model

// File: testbench/pbt_top_tb.sv
`timescale 1ns/1ps
`include "pbt_defs.svh"
`define CK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module pbt_top_tb import pbt_pkg::*;;
	localparam int ATT = 4;
	logic		core_clk = 1'b0;
	logic		rstn = 1'b0;
	logic [7:0]	reg_addr = 8'h00;
	logic [31:0]	reg_wdata = 32'h0;
	logic		reg_we = 1'b0;
	logic		reg_re = 1'b0;
	logic [31:0]	reg_rdata;
	pbt_addr_ph_t	ap = '0;
	pbt_busy_t	busy = '0;
	pbt_tgt_t	tgt;
	logic		init_dv = 1'b0;
	logic		init_last = 1'b0;
	logic		burst_lim = 1'b0;
	logic [7:0]	cache_line_dw = 8'h08;
	pbt_term_t	term;
	logic		dlv_mw, drop, serr_o, serr_oe_n;
	logic [2:0]	far_mode = 3'h0;
	logic [31:0]	v;
	int		err_count = 0, n_checks = 0, n_att = 0, cyc = 0, i, k;
	wire [7:0]	obs = {term, dlv_mw, drop, serr_oe_n};

	pbt_top #(.ATTEMPT_MAX(ATT)) dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.ap(ap), .busy(busy), .tgt(tgt), .init_dv(init_dv), .init_last(init_last),
		.burst_lim(burst_lim), .cache_line_dw(cache_line_dw), .term(term),
		.dlv_mw(dlv_mw), .drop(drop), .serr_o(serr_o), .serr_oe_n(serr_oe_n));
	pbt_far_model far (.core_clk(core_clk), .rstn(rstn), .mode(far_mode), .term(term),
		.drop(drop), .tgt(tgt));

	always #25 core_clk = !core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (tgt.att_end)
			n_att++;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge core_clk);
		reg_we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge core_clk);
		reg_re <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic wait_obs(input int b, input string n);
		for (k = 0; k < 60 && obs[b] !== 1'b1; k++)
			@(posedge core_clk) #1;
		`CK(n, 1'b1, obs[b])
	endtask
	task automatic idle();
		for (int j = 0; j < 40; j++) begin
			rd(`PBT_OFF_STAT);
			if (v[`PBT_ST_BUSY] === 1'b0)
				break;
		end
		`CK("idle", 1'b0, v[`PBT_ST_BUSY])
	endtask
	task automatic aph(input logic s, d, l, input pbt_cmd_t c, input logic [31:0] a);
		@(posedge core_clk);
		ap <= '{1'b1, s, d, l, c, a};
		@(posedge core_clk);
		ap.valid <= 1'b0;
		#1;
	endtask
	task automatic dv(input logic l, bl, exp_disc);
		@(posedge core_clk);
		init_dv <= 1'b1;
		init_last <= l;
		burst_lim <= bl;
		@(posedge core_clk);
		init_dv <= 1'b0;
		init_last <= 1'b0;
		burst_lim <= 1'b0;
		#1 `CK("dword disc", exp_disc, term.disc)
	endtask
	// an unclaimed address must leave the bridge silent; a claimed one
	// is retired through the wait-timer path so the bridge returns idle
	task automatic probe(input logic s, d, input logic [31:0] a, input logic ec, ep);
		aph(s, d, 1'b0, PBT_CMD_MEM_RD, a);
		`CK("claim", ec, term.claim)
		if (ec && !s)
			`CK("pref", ep, term.pref)
		if (ec) begin
			wait_obs(6, "wait retry");
			`CK("retry lag", 2, k)
		end
		idle();
	endtask
	task automatic refuse(input pbt_busy_t b, input logic l, input pbt_cmd_t c, input logic er);
		busy <= b;
		aph(1'b0, 1'b0, l, c, 32'h00200000);
		`CK("claim", 1'b1, term.claim)
		`CK("refuse retry", er, term.retry)
		busy <= '0;
		if (!er)
			dv(1'b1, 1'b0, 1'b0);
		idle();
	endtask
	task automatic npost(input logic [2:0] m, input int b, input string n);
		far_mode <= m;
		aph(1'b0, 1'b0, 1'b0, PBT_CMD_MEM_RD, 32'h00200000);
		wait_obs(b, n);
		`CK("answer lag", 2, k)
		`CK("abort", b == 4, term.tabort)
		idle();
	endtask
	task automatic pread(input logic [2:0] m, input pbt_cmd_t c, input logic [31:0] a);
		far_mode <= m;
		aph(1'b0, 1'b0, 1'b0, c, a);
		`CK("pref claim", 2'b11, {term.claim, term.pref})
		repeat (2) @(posedge core_clk);
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		`CK("reset outs", 3'b001, {drop, serr_o, serr_oe_n})
		rstn <= 1'b1;
		rd(`PBT_OFF_MEM);
		`CK("mem reg", 32'h0, v)
		rd(`PBT_OFF_PMEM);
		`CK("pmem reg", 32'h0, v)
		rd(8'h40);
		`CK("unmapped", 32'h0, v)
		probe(0, 0, 32'h000ffffc, 1, 0);
		probe(0, 0, 32'h00100000, 0, 0);
		probe(1, 0, 32'h000ffffc, 0, 0);
		probe(1, 0, 32'h00100000, 1, 0);
		$display("test reset decode done");
		wr(`PBT_OFF_MEM, 32'h00300020);
		wr(`PBT_OFF_PMEM, 32'h00500050);
		probe(0, 0, 32'h00200000, 1, 0);
		probe(0, 0, 32'h003ffffc, 1, 0);
		probe(0, 0, 32'h00400000, 0, 0);
		probe(0, 0, 32'h005ffffc, 1, 1);
		probe(1, 0, 32'h00400000, 1, 0);
		probe(1, 0, 32'h00500000, 0, 0);
		probe(0, 1, 32'h00200000, 0, 0);
		probe(1, 1, 32'h00200000, 1, 0);
		wr(`PBT_OFF_CTRL, 32'h8);
		probe(0, 0, 32'h000a0000, 1, 1);
		probe(0, 0, 32'h000bfffc, 1, 1);
		probe(0, 0, 32'h000c0000, 0, 0);
		probe(1, 0, 32'h000a0000, 0, 0);
		wr(`PBT_OFF_CTRL, 32'h0);
		wr(`PBT_OFF_MEM, 32'h00100020);
		wr(`PBT_OFF_PMEM, 32'h00400050);
		probe(0, 0, 32'h00200000, 0, 0);
		probe(1, 0, 32'h00500000, 1, 0);
		wr(`PBT_OFF_MEM, 32'h00300020);
		wr(`PBT_OFF_PMEM, 32'h00500050);
		$display("test range decode done");
		refuse(5'b10000, 0, PBT_CMD_MEM_RD, 1);
		refuse(5'b00100, 0, PBT_CMD_MEM_WR, 1);
		refuse(5'b00010, 0, PBT_CMD_MEM_RD, 1);
		refuse(5'b00001, 1, PBT_CMD_MEM_RD, 1);
		far_mode <= 3'h6;
		refuse(5'b01011, 0, PBT_CMD_MEM_WR, 0);
		$display("test retry done");
		npost(3'h1, 5, "single disc");
		npost(3'h2, 4, "target abort");
		wr(`PBT_OFF_CTRL, 32'h4);
		npost(3'h3, 4, "abort mode 1");
		wr(`PBT_OFF_CTRL, 32'h0);
		npost(3'h3, 5, "abort mode 0");
		$display("test non-posted done");
		pread(3'h1, PBT_CMD_MEM_RD, 32'h00500018);
		dv(0, 0, 0);
		dv(0, 0, 1);
		idle();
		pread(3'h1, PBT_CMD_MEM_RD_MULT, 32'h005003fc);
		dv(0, 0, 1);
		idle();
		pread(3'h1, PBT_CMD_MEM_RD, 32'h00500000);
		dv(0, 1, 1);
		idle();
		pread(3'h7, PBT_CMD_MEM_RD, 32'h00500000);
		dv(0, 0, 1);
		idle();
		$display("test prefetch done");
		far_mode <= 3'h6;
		aph(0, 0, 0, PBT_CMD_MEM_WR, 32'h002003f8);
		dv(0, 0, 0);
		dv(0, 0, 1);
		idle();
		aph(0, 0, 0, PBT_CMD_MWI, 32'h0020001c);
		dv(0, 0, 1);
		idle();
		$display("test write boundary done");
		wr(`PBT_OFF_CTRL, 32'h1);
		far_mode <= 3'h4;
		aph(0, 0, 0, PBT_CMD_MEM_WR, 32'h00200000);
		n_att = 0;
		for (i = 1; i <= 8; i++)
			dv(0, 0, i == 8);
		wait_obs(1, "drop");
		`CK("attempts", ATT, n_att)
		`CK("serr driven", 1'b0, serr_oe_n)
		rd(`PBT_OFF_STAT);
		`CK("fail flag", 1'b1, v[`PBT_ST_DLV_FAIL])
		wr(`PBT_OFF_STAT, 32'h1);
		rd(`PBT_OFF_STAT);
		`CK("fail clear", 1'b0, v[`PBT_ST_DLV_FAIL])
		wr(`PBT_OFF_CTRL, 32'h3);
		far_mode <= 3'h5;
		cache_line_dw <= 8'h10;
		aph(0, 0, 0, PBT_CMD_MWI, 32'h00200000);
		for (i = 1; i <= 8; i++)
			dv(0, 0, i == 8);
		wait_obs(2, "plain write");
		wait_obs(1, "drop");
		`CK("serr held", 1'b1, serr_oe_n)
		cache_line_dw <= 8'h08;
		far_mode <= 3'h0;
		idle();
		$display("test delivery failure done");
		finish_test();
	end
endmodule // pbt_top_tb
